// file: shared/pae_map.svh
`ifndef PAE_MAP_SVH
`define PAE_MAP_SVH
// Type codes
`define PAE_TYPE_OFF 5'h00
`define PAE_TYPE_BAND_OUT 5'h01
`define PAE_TYPE_DEV_HI 5'h02
`define PAE_TYPE_DEV_LO 5'h03
`define PAE_TYPE_BAND_IN 5'h04
`define PAE_TYPE_BAND_OUT_SB 5'h05
`define PAE_TYPE_DEV_HI_SB 5'h06
`define PAE_TYPE_DEV_LO_SB 5'h07
`define PAE_TYPE_ABS_HI 5'h08
`define PAE_TYPE_ABS_LO 5'h09
`define PAE_TYPE_ABS_HI_SB 5'h0A
`define PAE_TYPE_ABS_LO_SB 5'h0B
`define PAE_TYPE_LOOP_BREAK 5'h0C
`define PAE_TYPE_RATE 5'h0D
`define PAE_TYPE_SP_HI 5'h0E
`define PAE_TYPE_SP_LO 5'h0F
`define PAE_TYPE_OUT_HI 5'h10
`define PAE_TYPE_OUT_LO 5'h11
`define PAE_TYPE_EXT_HI 5'h12
`define PAE_TYPE_EXT_LO 5'h13
`define PAE_TYPE_RESET 5'h02
// Timing
`define PAE_CLK_HZ 125000000
`define PAE_DELAY_MAX_S 999
`endif

// file: shared/pae_pkg.sv
package pae_pkg;
    localparam int PAE_CHANNELS = 4;
    localparam int PAE_VW = 16;

    typedef struct packed {
        logic signed [15:0] measured_value;
        logic signed [15:0] target_setpoint;
        logic signed [15:0] external_target;
        logic signed [15:0] heat_output;
        logic signed [15:0] cool_output;
        logic heat_cool_mode;
        logic external_fitted;
        logic loop_break_alarm;
        logic rate_alarm;
    } pae_proc_type;

    typedef struct packed {
        logic [4:0] type_code;
        logic signed [15:0] alarm_value;
        logic signed [15:0] upper_dev;
        logic signed [15:0] lower_dev;
        logic [9:0] on_delay_s;
        logic [9:0] off_delay_s;
    } pae_cfg_type;

    typedef enum logic [1:0] {
        PAE_IDLE,
        PAE_ON_WAIT,
        PAE_ACTIVE,
        PAE_OFF_WAIT
    } pae_dly_state_type;
endpackage

// file: hdl/pae_delay.sv
`timescale 1ns/1ps
`include "pae_map.svh"
module pae_delay (
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic sec_tick, // One pulse per second
    input wire logic raw, // Undelayed condition
    input wire logic [9:0] on_delay_s, // ON delay seconds
    input wire logic [9:0] off_delay_s, // OFF delay seconds
    output logic out // Delayed alarm output
);
    pae_pkg::pae_dly_state_type state_reg, state_next;
    logic [9:0] cnt_reg, cnt_next;
    wire on_done = (on_delay_s == 10'h000) || (sec_tick && cnt_reg + 10'h001 >= on_delay_s);
    wire off_done = (off_delay_s == 10'h000) || (sec_tick && cnt_reg + 10'h001 >= off_delay_s);

    always_comb begin
        state_next = state_reg;
        cnt_next = sec_tick ? cnt_reg + 10'h001 : cnt_reg;
        case (state_reg)
            pae_pkg::PAE_IDLE: begin
                cnt_next = 10'h000;
                if (raw) begin
                    state_next = (on_delay_s == 10'h000) ? pae_pkg::PAE_ACTIVE : pae_pkg::PAE_ON_WAIT;
                end
            end
            pae_pkg::PAE_ON_WAIT: begin
                if (!raw) begin
                    state_next = pae_pkg::PAE_IDLE;
                end else if (on_done) begin
                    state_next = pae_pkg::PAE_ACTIVE;
                end
            end
            pae_pkg::PAE_ACTIVE: begin
                cnt_next = 10'h000;
                if (!raw) begin
                    state_next = (off_delay_s == 10'h000) ? pae_pkg::PAE_IDLE : pae_pkg::PAE_OFF_WAIT;
                end
            end
            pae_pkg::PAE_OFF_WAIT: begin
                if (raw) begin
                    state_next = pae_pkg::PAE_ACTIVE;
                end else if (off_done) begin
                    state_next = pae_pkg::PAE_IDLE;
                end
            end
            default: state_next = pae_pkg::PAE_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= pae_pkg::PAE_IDLE;
            cnt_reg <= 10'h000;
            out <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            out <= (state_next == pae_pkg::PAE_ACTIVE) || (state_next == pae_pkg::PAE_OFF_WAIT);
        end
    end
endmodule // pae_delay

// file: hdl/pae_evaluator.sv
`timescale 1ns/1ps
`include "pae_map.svh"
// Contract
// - Per-channel type code, default code 2
// - ON and OFF delays, 0 to 999 s; the 10-bit delay fields take up to 1023 s, unchecked
// - Code 1: value outside deviation band
// - Code 2: value above setpoint by deviation
// - Code 3: value below setpoint by deviation
// - Code 4: value inside deviation band
// - Code 5: code 1 plus standby
// - Code 6: code 2 plus standby
// - Code 7: code 3 plus standby
// - Code 8: value above alarm value
// - Code 9: value below alarm value
// - Code 10: code 8 plus standby
// - Code 11: code 9 plus standby
// - Code 12 loop break, channel 0 only
// - Code 13 rate-of-change alarm
// - Code 14: setpoint above alarm value
// - Code 15: setpoint below alarm value
// - Code 16: output above alarm value
// - Code 17: output below alarm value
// - Code 18: external target above value
// - Code 19: external target below value
// - Channel 0 defaults to heater fault alarm
// - Heat/cool: 16 heating, 17 cooling only
// - Code 5 off when hysteresis overlaps
// - Codes 18/19 need external input fitted
module pae_evaluator #(
    parameter int SEC_CYCLES = `PAE_CLK_HZ // Cycles per second, shorten in simulation
) (
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic sample_tick, // Controller sampling pulse
    input wire pae_pkg::pae_proc_type proc, // Loop values, same clock domain
    input wire pae_pkg::pae_cfg_type [3:0] cfg, // Per-channel settings
    input wire logic cfg_load, // Pulse: latch cfg into channels
    input wire logic setpoint_changed, // Pulse: re-arm standby
    input wire logic heater_fault_variant, // Heater fault detection fitted
    input wire logic heater_burnout_detect, // Heater burnout seen
    input wire logic heater_short_detect, // Heater short seen
    input wire logic ch0_assign_alarm, // Channel 0 assigned as alarm
    input wire logic [15:0] hyst, // Alarm hysteresis width
    output logic [3:0] aux_out, // Auxiliary output drive
    output logic [3:0] raw_alarm, // Undelayed alarm state
    output logic [3:0] standby_armed, // Standby still suppressing
    output logic heater_fault_alarm, // Heater fault alarm on channel 0
    output logic [4:0] ch0_type_shown // Channel 0 type, zero when hidden
);
    localparam int PAE_N = pae_pkg::PAE_CHANNELS;
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);

    logic [SEC_W-1:0] sec_cnt_reg;
    logic sec_tick;
    logic [4:0] type_reg [PAE_N];
    pae_pkg::pae_cfg_type cfg_reg [PAE_N];
    logic [PAE_N-1:0] cond_reg, standby_reg, delayed;
    wire hf_mode = heater_fault_variant && !ch0_assign_alarm;

    assign sec_tick = (sec_cnt_reg == SEC_W'(SEC_CYCLES - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sec_cnt_reg <= '0;
        end else begin
            sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + SEC_W'(1);
        end
    end

    genvar g;
    generate
        for (g = 0; g < PAE_N; g++) begin : gen_ch
            wire signed [17:0] pv = 18'(proc.measured_value);
            wire signed [17:0] sp = 18'(proc.target_setpoint);
            wire signed [17:0] xv = 18'(cfg_reg[g].alarm_value);
            wire signed [17:0] hi_lim = sp + 18'(cfg_reg[g].upper_dev);
            wire signed [17:0] lo_lim = sp - 18'(cfg_reg[g].lower_dev);
            wire signed [17:0] hy = 18'($signed({1'b0, hyst}));
            wire [4:0] t = type_reg[g];
            wire t_accept;
            wire hys_overlap;
            logic c_next;
            // loop break code accepted on channel 0 only
            assign t_accept = (cfg[g].type_code <= `PAE_TYPE_EXT_LO)
                && (g == 0 || cfg[g].type_code != `PAE_TYPE_LOOP_BREAK)
                && ((cfg[g].type_code != `PAE_TYPE_EXT_HI && cfg[g].type_code != `PAE_TYPE_EXT_LO)
                || proc.external_fitted);
            assign hys_overlap = (hi_lim - hy) <= (lo_lim + hy);

            always_comb begin
                c_next = 1'b0;
                case (t)
                    `PAE_TYPE_OFF: c_next = 1'b0;
                    `PAE_TYPE_BAND_OUT, `PAE_TYPE_BAND_OUT_SB: c_next = (pv > hi_lim) || (pv < lo_lim);
                    `PAE_TYPE_DEV_HI, `PAE_TYPE_DEV_HI_SB: c_next = (pv - sp) >= xv;
                    `PAE_TYPE_DEV_LO, `PAE_TYPE_DEV_LO_SB: c_next = (sp - pv) >= xv;
                    `PAE_TYPE_BAND_IN: c_next = (pv >= lo_lim) && (pv <= hi_lim);
                    `PAE_TYPE_ABS_HI, `PAE_TYPE_ABS_HI_SB: c_next = pv > xv;
                    `PAE_TYPE_ABS_LO, `PAE_TYPE_ABS_LO_SB: c_next = pv < xv;
                    `PAE_TYPE_LOOP_BREAK: c_next = (g == 0) && proc.loop_break_alarm;
                    `PAE_TYPE_RATE: c_next = proc.rate_alarm;
                    `PAE_TYPE_SP_HI: c_next = sp > xv;
                    `PAE_TYPE_SP_LO: c_next = sp < xv;
                    `PAE_TYPE_OUT_HI: c_next = 18'(proc.heat_output) > xv;
                    // output lower, cooling side under heat/cool
                    `PAE_TYPE_OUT_LO: c_next = (proc.heat_cool_mode ? 18'(proc.cool_output)
                        : 18'(proc.heat_output)) < xv;
                    `PAE_TYPE_EXT_HI: c_next = proc.external_fitted && (18'(proc.external_target) > xv);
                    `PAE_TYPE_EXT_LO: c_next = proc.external_fitted && (18'(proc.external_target) < xv);
                    default: c_next = 1'b0;
                endcase
            end

            wire is_sb = (t == `PAE_TYPE_BAND_OUT_SB) || (t == `PAE_TYPE_DEV_HI_SB)
                || (t == `PAE_TYPE_DEV_LO_SB) || (t == `PAE_TYPE_ABS_HI_SB) || (t == `PAE_TYPE_ABS_LO_SB);

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    type_reg[g] <= `PAE_TYPE_RESET;
                    cfg_reg[g] <= '0;
                    cond_reg[g] <= 1'b0;
                    standby_reg[g] <= 1'b1;
                end else begin
                    if (cfg_load && t_accept) begin
                        type_reg[g] <= cfg[g].type_code;
                        cfg_reg[g] <= cfg[g];
                    end else if (cfg_load) begin
                        cfg_reg[g] <= '{type_code: type_reg[g], alarm_value: cfg[g].alarm_value,
                            upper_dev: cfg[g].upper_dev, lower_dev: cfg[g].lower_dev,
                            on_delay_s: cfg[g].on_delay_s, off_delay_s: cfg[g].off_delay_s};
                    end
                    if (setpoint_changed || cfg_load) begin
                        standby_reg[g] <= 1'b1;
                    end else if (sample_tick && !c_next) begin
                        standby_reg[g] <= 1'b0;
                    end
                    if (sample_tick) begin
                        cond_reg[g] <= c_next && !(is_sb && standby_reg[g])
                            && !(t == `PAE_TYPE_BAND_OUT_SB && hys_overlap);
                    end
                end
            end

            pae_delay u_delay (
                .clk(clk),
                .nrst(nrst),
                .sec_tick(sec_tick),
                .raw(cond_reg[g]),
                .on_delay_s(cfg_reg[g].on_delay_s),
                .off_delay_s(cfg_reg[g].off_delay_s),
                .out(delayed[g])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aux_out <= '0;
            heater_fault_alarm <= 1'b0;
            ch0_type_shown <= 5'h00;
            raw_alarm <= '0;
            standby_armed <= '0;
        end else begin
            raw_alarm <= cond_reg;
            standby_armed <= standby_reg;
            // channel 0 serves heater fault by default
            heater_fault_alarm <= hf_mode && (heater_burnout_detect || heater_short_detect);
            aux_out <= {delayed[PAE_N-1:1],
                hf_mode ? (heater_burnout_detect || heater_short_detect) : delayed[0]};
            // type hidden while heater fault owns channel 0
            ch0_type_shown <= hf_mode ? 5'h00 : type_reg[0];
        end
    end
endmodule // pae_evaluator

// file: tb/pae_loop_model.sv
`timescale 1ns/1ps
module pae_loop_model #(
    parameter int TICK_GAP = 4 // Cycles between samples
) (
    input wire logic clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire pae_pkg::pae_proc_type proc_req, // Values to present
    output pae_pkg::pae_proc_type proc, // Loop values out
    output logic sample_tick // Sampling pulse
);
    logic [3:0] gap_reg;
    // Values move only on the clock, so a sample never sees a half update
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gap_reg <= 4'h0;
            proc <= '0;
        end else begin
            gap_reg <= (gap_reg == 4'(TICK_GAP - 1)) ? 4'h0 : gap_reg + 4'h1;
            proc <= proc_req;
        end
    end
    assign sample_tick = (gap_reg == 4'h0) && nrst;
endmodule // pae_loop_model

// file: tb/pae_evaluator_props.sv
`timescale 1ns/1ps
module pae_evaluator_props (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic sample_tick, // Sample pulse
    input wire logic cfg_load, // Config load
    input wire logic setpoint_changed, // Re-arm pulse
    input wire logic heater_fault_variant, // Heater variant
    input wire logic ch0_assign_alarm, // Channel 0 as alarm
    input wire logic [3:0] aux_out, // Delayed outputs
    input wire logic [3:0] raw_alarm, // Undelayed state
    input wire logic [3:0] standby_armed, // Standby pending
    input wire logic heater_fault_alarm, // Heater alarm
    input wire logic [4:0] ch0_type_shown // Shown type
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_raw_on_sample: assert property (!$past(sample_tick, 2) |-> $stable(raw_alarm))
        else $error("raw alarm moved without a sample");
    a_aux_needs_raw: assert property ($rose(aux_out[1]) |-> $past(raw_alarm[1]))
        else $error("aux rose without condition");
    a_aux_fall_cause: assert property ($fell(aux_out[2]) |-> !$past(raw_alarm[2]))
        else $error("aux fell while condition held");
    a_type_hidden: assert property (heater_fault_variant && !ch0_assign_alarm |=> ch0_type_shown == 5'h00)
        else $error("channel 0 type shown in heater mode");
    a_type_range: assert property (ch0_type_shown <= 5'h13)
        else $error("channel 0 type out of range");
    a_heater_quiet: assert property (!heater_fault_variant |=> !heater_fault_alarm)
        else $error("heater alarm without heater variant");
    a_arm_cause: assert property ($rose(standby_armed[1]) |->
        $past(cfg_load, 2) || $past(setpoint_changed, 2) || !$past(nrst, 2))
        else $error("standby armed without cause");
    a_arm_release: assert property ($fell(standby_armed[1]) |->
        !raw_alarm[1] && ($past(sample_tick) || $past(sample_tick, 2)))
        else $error("standby released without clean sample");
endmodule // pae_evaluator_props
bind pae_evaluator pae_evaluator_props i_props (.clk(clk), .nrst(nrst), .sample_tick(sample_tick),
    .cfg_load(cfg_load), .setpoint_changed(setpoint_changed), .heater_fault_variant(heater_fault_variant),
    .ch0_assign_alarm(ch0_assign_alarm), .aux_out(aux_out), .raw_alarm(raw_alarm),
    .standby_armed(standby_armed), .heater_fault_alarm(heater_fault_alarm), .ch0_type_shown(ch0_type_shown));

// file: tb/pae_evaluator_test.sv
`timescale 1ns/1ps
module pae_evaluator_test;
    localparam logic [37:0] ROWS [18] = '{
        {5'h00, 16'h0000, 16'h01F4, 1'b0}, {5'h01, 16'h0000, 16'h006A, 1'b1}, {5'h01, 16'h0000, 16'h0064, 1'b0},
        {5'h02, 16'h0005, 16'h0069, 1'b1}, {5'h02, 16'h0005, 16'h0068, 1'b0}, {5'h03, 16'h0005, 16'h005F, 1'b1},
        {5'h03, 16'h0005, 16'h0060, 1'b0}, {5'h04, 16'h0000, 16'h0064, 1'b1}, {5'h04, 16'h0000, 16'h006A, 1'b0},
        {5'h0E, 16'h0063, 16'h0000, 1'b1}, {5'h0E, 16'h0064, 16'h0000, 1'b0}, {5'h0F, 16'h0065, 16'h0000, 1'b1},
        {5'h10, 16'h000A, 16'h000B, 1'b1}, {5'h11, 16'h000A, 16'h0009, 1'b1}, {5'h12, 16'h000A, 16'h000B, 1'b1},
        {5'h13, 16'h000A, 16'h0009, 1'b1}, {5'h12, 16'h000A, 16'h000A, 1'b0}, {5'h13, 16'h000A, 16'h000A, 1'b0}};
    localparam logic [52:0] SB [4] = '{{5'h06, 16'h0005, 16'h006E, 16'h0064}, {5'h07, 16'h0005, 16'h005A, 16'h0064},
        {5'h0A, 16'h0078, 16'h0082, 16'h0064}, {5'h0B, 16'h0050, 16'h0046, 16'h0064}};
    logic clk = 1'b0, nrst = 1'b0, cfg_load = 1'b0, setpoint_changed = 1'b0, hf_variant = 1'b0;
    logic burnout = 1'b0, shorted = 1'b0, ch0_assign = 1'b1, sample_tick, heater_fault_alarm;
    logic [15:0] hyst = 16'h0001, rx;
    logic [1:0] chk = 2'h0;
    logic [3:0] aux_out, raw_alarm, standby_armed;
    logic [4:0] ch0_type_shown, ent, bit_q[$], type_q[$];
    wire [12:0] seen = {standby_armed, heater_fault_alarm, raw_alarm, aux_out};
    pae_pkg::pae_proc_type proc_req = '0, proc;
    pae_pkg::pae_cfg_type [3:0] cfg = '0;
    int miscompares = 0, compares = 0;
    integer seed = 32'ha271;
    always #4 clk = ~clk;
    pae_loop_model i_loop (.clk(clk), .nrst(nrst), .proc_req(proc_req), .proc(proc), .sample_tick(sample_tick));
    pae_evaluator #(.SEC_CYCLES(10)) i_dut (.clk(clk), .nrst(nrst), .sample_tick(sample_tick), .proc(proc),
        .cfg(cfg), .cfg_load(cfg_load), .setpoint_changed(setpoint_changed), .heater_fault_variant(hf_variant),
        .heater_burnout_detect(burnout), .heater_short_detect(shorted), .ch0_assign_alarm(ch0_assign),
        .hyst(hyst), .aux_out(aux_out), .raw_alarm(raw_alarm), .standby_armed(standby_armed),
        .heater_fault_alarm(heater_fault_alarm), .ch0_type_shown(ch0_type_shown));
    task automatic check_val(input string what, input logic [4:0] exp, input logic [4:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Oldest note is compared when the driver flags a settled result
    always @(posedge clk) begin
        if (chk == 2'h1) begin
            ent = bit_q.pop_front();
            check_val($sformatf("alarm bit %0d", ent[4:1]), {4'h0, ent[0]}, {4'h0, seen[ent[4:1]]});
        end else if (chk == 2'h2) begin
            check_val("channel 0 type", type_q.pop_front(), ch0_type_shown);
        end
    end
    task automatic flag(input logic [1:0] kind);
        chk <= kind;
        @(posedge clk);
        chk <= 2'h0;
        @(posedge clk);
    endtask
    task automatic expect_bit(input logic [3:0] sel, input logic exp);
        bit_q.push_back({sel, exp});
        flag(2'h1);
    endtask
    task automatic expect_type(input logic [4:0] exp);
        type_q.push_back(exp);
        flag(2'h2);
    endtask
    task automatic expect_ch(input logic [1:0] ch, input logic raw, input logic aux);
        expect_bit({2'h1, ch}, raw);
        expect_bit({2'h0, ch}, aux);
    endtask
    task automatic setcfg(input logic [1:0] ch, input logic [4:0] code, input logic [15:0] x, input logic [9:0] on_s);
        cfg[ch].type_code <= code;
        cfg[ch].alarm_value <= x;
        cfg[ch].on_delay_s <= on_s;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(posedge clk);
    endtask
    task automatic probe(input logic [15:0] v, input int wait_n);
        proc_req.measured_value <= v;
        proc_req.heat_output <= v;
        proc_req.external_target <= v;
        repeat (wait_n) @(posedge clk);
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            cfg[i].upper_dev = 16'h0005;
            cfg[i].lower_dev = 16'h0005;
        end
        proc_req.target_setpoint = 16'h0064;
        proc_req.external_fitted = 1'b1;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        expect_type(5'h02);
        foreach (ROWS[i]) begin
            setcfg(2'h1, ROWS[i][37:33], ROWS[i][32:17], 10'h000);
            probe(ROWS[i][16:1], 12);
            expect_ch(2'h1, ROWS[i][0], ROWS[i][0]);
        end
        for (int i = 0; i < 6; i++) begin
            rx = 16'($random(seed) % 1000);
            setcfg(2'h1, i[0] ? 5'h09 : 5'h08, rx, 10'h000);
            probe(i[0] ? rx - 16'h0001 : rx + 16'h0001, 12);
            expect_ch(2'h1, 1'b1, 1'b1);
            probe(rx, 12);
            expect_ch(2'h1, 1'b0, 1'b0);
        end
        $display("test codes done");
        foreach (SB[i]) begin
            // Measured value in place before the load, so no stale sample releases standby
            probe(SB[i][31:16], 4);
            setcfg(2'h1, SB[i][52:48], SB[i][47:32], 10'h000);
            probe(SB[i][31:16], 12);
            expect_bit(4'h1, 1'b0);
            expect_bit(4'hA, 1'b1);
            probe(SB[i][15:0], 12);
            expect_bit(4'hA, 1'b0);
            probe(SB[i][31:16], 12);
            expect_ch(2'h1, 1'b1, 1'b1);
        end
        setpoint_changed <= 1'b1;
        @(posedge clk);
        setpoint_changed <= 1'b0;
        repeat (12) @(posedge clk);
        expect_bit(4'h1, 1'b0);
        expect_bit(4'hA, 1'b1);
        setcfg(2'h1, 5'h05, 16'h0000, 10'h000);
        hyst <= 16'h0010;
        probe(16'h0064, 12);
        probe(16'h00C8, 12);
        expect_bit(4'h1, 1'b0);
        hyst <= 16'h0001;
        probe(16'h0064, 12);
        probe(16'h00C8, 12);
        expect_bit(4'h1, 1'b1);
        $display("test standby done");
        setcfg(2'h1, 5'h09, 16'h000A, 10'h000);
        proc_req.loop_break_alarm <= 1'b1;
        setcfg(2'h1, 5'h0C, 16'h000A, 10'h000);
        setcfg(2'h1, 5'h14, 16'h000A, 10'h000);
        proc_req.external_fitted <= 1'b0;
        // Loop model passes values one cycle late
        @(posedge clk);
        setcfg(2'h1, 5'h12, 16'h000A, 10'h000);
        proc_req.external_fitted <= 1'b1;
        probe(16'h0005, 12);
        expect_ch(2'h1, 1'b1, 1'b1);
        proc_req.heat_cool_mode <= 1'b1;
        proc_req.cool_output <= 16'h0009;
        setcfg(2'h1, 5'h11, 16'h000A, 10'h000);
        probe(16'h0014, 12);
        expect_ch(2'h1, 1'b1, 1'b1);
        proc_req.heat_cool_mode <= 1'b0;
        setcfg(2'h0, 5'h0C, 16'h0000, 10'h000);
        probe(16'h0064, 12);
        expect_bit(4'h4, 1'b1);
        expect_type(5'h0C);
        proc_req.loop_break_alarm <= 1'b0;
        proc_req.rate_alarm <= 1'b1;
        setcfg(2'h0, 5'h0D, 16'h0000, 10'h000);
        probe(16'h0064, 12);
        expect_bit(4'h4, 1'b1);
        $display("test refusals done");
        setcfg(2'h2, 5'h08, 16'h000A, 10'h002);
        probe(16'h000B, 12);
        expect_ch(2'h2, 1'b1, 1'b0);
        probe(16'h000B, 24);
        expect_bit(4'h2, 1'b1);
        probe(16'h0000, 24);
        expect_bit(4'h2, 1'b0);
        hf_variant <= 1'b1;
        ch0_assign <= 1'b0;
        burnout <= 1'b1;
        repeat (30) @(posedge clk);
        expect_type(5'h00);
        expect_bit(4'h8, 1'b1);
        expect_bit(4'h0, 1'b1);
        burnout <= 1'b0;
        shorted <= 1'b1;
        repeat (30) @(posedge clk);
        expect_bit(4'h8, 1'b1);
        $display("test delay and heater done");
        test_done();
    end
endmodule // pae_evaluator_test
